//--- hdl/istr_pkg.sv
// Purpose: Shared constants, types and helpers for the IMU sample timing block
// Assumes: Byte-wide register port, one 125 MHz clock
// Notes:   Rates map onto sensortime bits; code c selects bit 16-c
package istr_pkg;

  localparam int ST_W = 24;

  // Timing, in picoseconds
  localparam longint ST_TICK_PS      = 64'd39062500;   // 39.0625 us sensortime step
  localparam longint CLK_PERIOD_PS   = 64'd8000;       // 125 MHz
  localparam longint DRDY_HOLD_PS    = 64'd156250000;  // one 6400 Hz period
  localparam int     DRDY_HOLD_TICKS = int'(DRDY_HOLD_PS / ST_TICK_PS);

  // Sensortime grid bits
  localparam logic [4:0] SLOT_BIT      = 5'h04;  // 1600 Hz acquisition slot
  localparam logic [4:0] TEMP_FAST_BIT = 5'h08;  // 100 Hz
  localparam logic [4:0] TEMP_SLOW_BIT = 5'h0F;  // 0.78 Hz
  localparam logic [4:0] ODR_BIT_BASE  = 5'h10;

  // Valid rate codes
  localparam logic [3:0] ACC_NP_MIN = 4'h5;  // 12.5 Hz
  localparam logic [3:0] ACC_NP_MAX = 4'hC;  // 1600 Hz
  localparam logic [3:0] ACC_LP_MIN = 4'h1;  // 0.78 Hz
  localparam logic [3:0] ACC_LP_MAX = 4'hA;  // 400 Hz
  localparam logic [3:0] GYR_NP_MIN = 4'h6;  // 25 Hz
  localparam logic [3:0] GYR_NP_MAX = 4'hD;  // 3200 Hz
  localparam logic [3:0] GYR_LP_MIN = 4'h6;  // 25 Hz
  localparam logic [3:0] GYR_LP_MAX = 4'h8;  // 100 Hz
  localparam logic [2:0] GYR_LP_AVG_LOG2 = 3'h2;
  localparam logic [2:0] GYR_BWP_NORMAL  = 3'h2;

  // Register offsets
  localparam logic [7:0] STATUS_ADDR     = 8'h00;
  localparam logic [7:0] INT_STATUS_ADDR = 8'h01;
  localparam logic [7:0] SENSOR_POWER_CONTROL_ADDR   = 8'h04;
  localparam logic [7:0] POWER_CONFIGURATION_ADDR   = 8'h05;
  localparam logic [7:0] ACC_CONF_ADDR   = 8'h06;
  localparam logic [7:0] GYR_CONF_ADDR   = 8'h07;
  localparam logic [7:0] INT_MAP_ADDR    = 8'h08;
  localparam logic [7:0] ACC_DATA_ADDR   = 8'h0C;
  localparam logic [7:0] GYR_DATA_ADDR   = 8'h12;
  localparam logic [7:0] TEMP_LO_ADDR    = 8'h18;
  localparam logic [7:0] TEMP_HI_ADDR    = 8'h19;
  localparam logic [7:0] ST_B0_ADDR      = 8'h1A;
  localparam logic [7:0] ST_B1_ADDR      = 8'h1B;
  localparam logic [7:0] ST_B2_ADDR      = 8'h1C;

  // Field positions
  localparam int PWR_ACC_EN_BIT  = 0;
  localparam int PWR_GYR_EN_BIT  = 1;
  localparam int PWR_TEMP_EN_BIT = 2;
  localparam int CONF_ADV_PS_BIT = 0;
  localparam int CONF_STBY_BIT   = 1;
  localparam int MAP_LATCH_BIT   = 4;

  // Reset values
  localparam logic [7:0] SENSOR_POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] POWER_CONFIGURATION_RST = 8'h01;
  localparam logic [7:0] ACC_CONF_RST = 8'hA8;
  localparam logic [7:0] GYR_CONF_RST = 8'hA9;
  localparam logic [7:0] INT_MAP_RST  = 8'h00;

  // Temperature codes
  localparam logic [15:0] TEMP_INVALID = 16'h8000;
  localparam logic [15:0] TEMP_MIN     = 16'h8001;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } istr_axes_s;

  typedef struct packed {
    logic       perf;
    logic [2:0] bwp;
    logic [3:0] odr;
  } istr_conf_s;

  function automatic logic istr_on_grid(input logic [ST_W-1:0] st, input logic [4:0] b);
    return (st & ~({ST_W{1'b1}} << b)) == '0;
  endfunction

  function automatic logic [4:0] istr_odr_bit(input logic [3:0] code);
    return ODR_BIT_BASE - {1'b0, code};
  endfunction

  function automatic logic istr_odr_in(input logic [3:0] c, input logic [3:0] lo,
                                       input logic [3:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction

endpackage

//--- hdl/istr_sensortime.sv
// Purpose: Free-running 24-bit sensortime counter
// Assumes: Tick period given in picoseconds
// Notes:   Phase accumulator keeps the fractional clock count exact
`timescale 1ns/10ps
module istr_sensortime #(
  parameter longint TICK_PS = istr_pkg::ST_TICK_PS
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  output logic      [istr_pkg::ST_W-1:0]  st_q,
  output logic                            tick_q
);
  import istr_pkg::*;

  logic [31:0] ph_q;
  wire  [31:0] ph_sum_w = ph_q + CLK_PERIOD_PS[31:0];
  wire         wrap_w   = ph_sum_w >= TICK_PS[31:0];

  // Tick registers on the same edge as the increment so st_q is already new when tick_q is seen
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ph_q   <= '0;
      st_q   <= '0;
      tick_q <= 1'b0;
    end else begin
      ph_q   <= wrap_w ? ph_sum_w - TICK_PS[31:0] : ph_sum_w;
      st_q   <= wrap_w ? st_q + 24'h000001 : st_q; // [R20]
      tick_q <= wrap_w;
    end
  end

endmodule // istr_sensortime

//--- hdl/istr_sample_path.sv
// Purpose: Per-sensor sample timing, low power averaging and result register
// Assumes: Raw axes always valid; sensortime tick from istr_sensortime
// Notes:   Filter shaping is not modelled; performance mode takes the raw value
`timescale 1ns/10ps
module istr_sample_path (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        tick,
  input  wire logic [istr_pkg::ST_W-1:0]   st,
  input  wire logic [4:0]                  odr_bit,
  input  wire logic [2:0]                  avg_log2,
  input  wire logic                        lp,
  input  wire logic                        active,
  input  istr_pkg::istr_axes_s             raw,
  output istr_pkg::istr_axes_s             smp_q,
  output logic                             upd_q
);
  import istr_pkg::*;

  wire             ev_w    = tick && active && istr_on_grid(st, odr_bit); // [R21]
  wire             slot_w  = tick && istr_on_grid(st, SLOT_BIT);
  wire [4:0]       span_w  = odr_bit - SLOT_BIT;
  wire [2:0]       eff_w   = ({2'b00, avg_log2} > span_w) ? span_w[2:0] : avg_log2;
  wire [ST_W-1:0]  idx_w   = (st & ~({ST_W{1'b1}} << odr_bit)) >> SLOT_BIT;
  // Slots before this index are skipped: idle phase of the duty cycle
  wire [ST_W-1:0]  first_w = (24'h000001 << span_w) - (24'h000001 << eff_w); // [R4]
  wire             take_w  = lp && active && slot_w && (idx_w >= first_w); // [R3]
  logic [47:0]     res_w;

  genvar i;
  for (i = 0; i < 3; i++) begin : g_axis
    logic signed [22:0] sum_q;
    logic        [15:0] out_q;
    wire  signed [22:0] raw_w = 23'(signed'(raw[16*i +: 16]));
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        sum_q <= '0;
        out_q <= '0;
      end else if (ev_w) begin
        out_q <= lp ? 16'(sum_q >>> eff_w) : raw[16*i +: 16]; // [R1] [R4] [R12]
        sum_q <= take_w ? raw_w : '0;
      end else if (take_w) begin
        sum_q <= sum_q + raw_w; // [R3]
      end else if (!active) begin
        sum_q <= '0;
      end
    end
    assign res_w[16*i +: 16] = out_q;
  end

  assign smp_q = res_w;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= ev_w;
    end
  end

endmodule // istr_sample_path

//--- hdl/istr_top.sv
// Purpose: Sample timing, data-ready events and result readout of a six-axis IMU
// Assumes: Raw axis and temperature inputs always valid and synchronous to clk
// Notes:   Byte register port; read data stands in the cycle after the strobe
//
// Functional notes
// R1 - Accel performance filter samples equidistantly at eight rates, 12.5 to 1600 Hz.
// R2 - Low power applies when advanced power save set and filter select clear.
// R3 - Accel low power alternates idle and active phases at ten rates, 0.78-400 Hz.
// R4 - Accel low power averages two to the bandwidth samples; others skipped.
// R5 - Accel data-ready asserts on new results; non-latched clears after 6400 Hz period.
// R6 - Gyro data-ready asserts on new results; non-latched clears after 6400 Hz period.
// R7 - Reading any own data register clears that sensor's data-ready status.
// R8 - Host maps data-ready to an interrupt pin before expecting it there.
// R9 - Gyro axes are 16-bit two's complement, low byte read first.
// R10 - Reading an axis low byte freezes its high byte for a consistent pair.
// R11 - Host corrects gyro X by sign-extended cross-axis factor times Z over 512.
// R12 - Gyro performance filter: eight rates 25 Hz-3.2 kHz; 6.4 kHz only via FIFO.
// R13 - Gyro low power allows 25, 50, 100 Hz, averaging four samples.
// R14 - Gyro bandwidth field picks filter; value two means normal filter.
// R15 - Temperature is signed, zero at 23 C, 1/512 C steps, 0x8000 invalid.
// R16 - After temperature enable, result reads invalid until first measurement completes.
// R17 - Gyro enabled runs temperature at 100 Hz regardless of its enable.
// R18 - Gyro disabled follows temperature enable; updates at 0.78 Hz on grid.
// R19 - Gyro standby or fast power-up updates temperature every 1.28 s.
// R20 - 24-bit free-running sensortime advances every 39.0625 us, three byte registers.
// R21 - Every result update lands on the matching sensortime bit transition.
// R22 - A burst over the three sensortime bytes returns one captured value.
// R23 - Accel axes are 16-bit, low byte first, low read locks high byte.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
module istr_top #(
  parameter longint ST_TICK_PS = istr_pkg::ST_TICK_PS
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [7:0]            rdata,
  input  istr_pkg::istr_axes_s       acc_raw,
  input  istr_pkg::istr_axes_s       gyr_raw,
  input  wire logic [15:0]           temp_raw,
  output logic                       int1,
  output logic                       int2,
  output logic                       gyr_filt_normal
);
  import istr_pkg::*;

  // Control registers
  logic       [7:0]       sensor_power_control_q;
  logic       [7:0]       power_configuration_q;
  istr_conf_s             acc_conf_q;
  istr_conf_s             gyr_conf_q;
  logic       [7:0]       int_map_q;

  // Time base and results
  logic       [ST_W-1:0]  st_w;
  logic                   tick_w;
  istr_axes_s             acc_smp_w;
  istr_axes_s             gyr_smp_w;
  logic                   acc_upd_w;
  logic                   gyr_upd_w;
  logic       [15:0]      temp_q;
  logic                   temp_on_q;

  // Shadow copies for consistent multi-byte reads
  logic       [23:0]      acc_hi_q;
  logic       [23:0]      gyr_hi_q;
  logic       [7:0]       temp_hi_q;
  logic       [15:0]      st_snap_q;

  // Events
  logic       [1:0]       drdy_w;
  logic       [1:0]       int_stat_w;
  logic       [1:0]       pulse_w;
  logic       [1:0]       evt_w;

  // Read path
  logic       [7:0]       rd_mux_w;
  logic       [7:0]       rdata_q;
  logic                   filt_normal_q;

  function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'h06);
  endfunction

  function automatic logic [7:0] data_byte(input logic [47:0] smp, input logic [23:0] hi,
                                           input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    for (int a = 0; a < 3; a++) begin
      if (idx == 3'(2*a)) begin
        b = smp[16*a +: 8];
      end else if (idx == 3'(2*a + 1)) begin
        b = hi[8*a +: 8];
      end
    end
    return b;
  endfunction

  // Control decode
  wire acc_en_w   = sensor_power_control_q[PWR_ACC_EN_BIT];
  wire gyr_en_w   = sensor_power_control_q[PWR_GYR_EN_BIT];
  wire temp_en_w  = sensor_power_control_q[PWR_TEMP_EN_BIT];
  wire adv_ps_w   = power_configuration_q[CONF_ADV_PS_BIT];
  wire gyr_stby_w = power_configuration_q[CONF_STBY_BIT];
  wire latch_w    = int_map_q[MAP_LATCH_BIT];

  wire acc_lp_w = adv_ps_w & ~acc_conf_q.perf; // [R2]
  wire gyr_lp_w = adv_ps_w & ~gyr_conf_q.perf; // [R2]

  // Out-of-range codes produce no updates at all
  wire acc_ok_w = acc_lp_w ? istr_odr_in(acc_conf_q.odr, ACC_LP_MIN, ACC_LP_MAX)  // [R3]
                           : istr_odr_in(acc_conf_q.odr, ACC_NP_MIN, ACC_NP_MAX); // [R1]
  // The 6.4 kHz code lies above the register range, so results never update there
  wire gyr_ok_w = gyr_lp_w ? istr_odr_in(gyr_conf_q.odr, GYR_LP_MIN, GYR_LP_MAX)  // [R13]
                           : istr_odr_in(gyr_conf_q.odr, GYR_NP_MIN, GYR_NP_MAX); // [R12]

  wire acc_act_w = acc_en_w & acc_ok_w;
  wire gyr_act_w = gyr_en_w & ~gyr_stby_w & gyr_ok_w;

  wire [4:0] acc_bit_w = istr_odr_bit(acc_conf_q.odr);
  wire [4:0] gyr_bit_w = istr_odr_bit(gyr_conf_q.odr);

  istr_sensortime #(
    .TICK_PS (ST_TICK_PS)
  ) u_time (
    .clk     (clk),
    .reset_n (reset_n),
    .st_q    (st_w),
    .tick_q  (tick_w)
  );

  istr_sample_path u_acc (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (tick_w),
    .st       (st_w),
    .odr_bit  (acc_bit_w),
    .avg_log2 (acc_conf_q.bwp),
    .lp       (acc_lp_w),
    .active   (acc_act_w),
    .raw      (acc_raw),
    .smp_q    (acc_smp_w),
    .upd_q    (acc_upd_w)
  );

  // Gyro low power always averages four, whatever the bandwidth field holds
  istr_sample_path u_gyr (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (tick_w),
    .st       (st_w),
    .odr_bit  (gyr_bit_w),
    .avg_log2 (GYR_LP_AVG_LOG2), // [R13]
    .lp       (gyr_lp_w),
    .active   (gyr_act_w),
    .raw      (gyr_raw),
    .smp_q    (gyr_smp_w),
    .upd_q    (gyr_upd_w)
  );

  // Register writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sensor_power_control_q <= SENSOR_POWER_CONTROL_RST;
      power_configuration_q <= POWER_CONFIGURATION_RST;
      acc_conf_q <= ACC_CONF_RST;
      gyr_conf_q <= GYR_CONF_RST;
      int_map_q  <= INT_MAP_RST;
    end else if (wr_en) begin
      case (addr)
        SENSOR_POWER_CONTROL_ADDR: sensor_power_control_q <= wdata;
        POWER_CONFIGURATION_ADDR: power_configuration_q <= wdata;
        ACC_CONF_ADDR: acc_conf_q <= wdata;
        GYR_CONF_ADDR: gyr_conf_q <= wdata;
        INT_MAP_ADDR:  int_map_q  <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filt_normal_q <= 1'b0;
    end else begin
      filt_normal_q <= gyr_conf_q.bwp == GYR_BWP_NORMAL; // [R14]
    end
  end

  assign gyr_filt_normal = filt_normal_q;

  // Data-ready flags and pin events, index 0 accel, 1 gyro
  wire [1:0] upd_w     = {gyr_upd_w, acc_upd_w};
  wire [1:0] data_rd_w = {rd_en && in_blk(addr, GYR_DATA_ADDR),
                          rd_en && in_blk(addr, ACC_DATA_ADDR)};
  wire       stat_rd_w = rd_en && (addr == INT_STATUS_ADDR);

  genvar s;
  for (s = 0; s < 2; s++) begin : g_drdy
    logic       flag_q;
    logic       stat_q;
    logic [2:0] hold_q;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        flag_q <= 1'b0;
        stat_q <= 1'b0;
        hold_q <= '0;
      end else begin
        // A new sample in the clearing cycle keeps the flag set
        flag_q <= upd_w[s] | (flag_q & ~data_rd_w[s]); // [R7]
        stat_q <= upd_w[s] | (stat_q & ~stat_rd_w);
        if (upd_w[s]) begin
          hold_q <= 3'(DRDY_HOLD_TICKS); // [R5] [R6]
        end else if (tick_w && (hold_q != 3'h0)) begin
          hold_q <= hold_q - 3'h1;
        end
      end
    end
    assign drdy_w[s]     = flag_q;
    assign int_stat_w[s] = stat_q;
    assign pulse_w[s]    = hold_q != 3'h0;
  end

  // Non-latched pulse length rounds to whole sensortime steps
  assign evt_w = latch_w ? int_stat_w : pulse_w; // [R5] [R6]
  // Nothing reaches a pin until software maps it there
  assign int1  = |(evt_w & int_map_q[1:0]); // [R8]
  assign int2  = |(evt_w & int_map_q[3:2]); // [R8]

  // Temperature
  wire       temp_on_w  = gyr_en_w | temp_en_w; // [R17] [R18]
  wire [4:0] temp_bit_w = (gyr_en_w & ~gyr_stby_w) ? TEMP_FAST_BIT  // [R17]
                                                  : TEMP_SLOW_BIT; // [R18] [R19]
  wire       temp_ev_w  = tick_w && temp_on_q && istr_on_grid(st_w, temp_bit_w); // [R21]
  // The raw sensor must never alias the invalid code
  wire [15:0] temp_clip_w = (temp_raw == TEMP_INVALID) ? TEMP_MIN : temp_raw; // [R15]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_on_q <= 1'b0;
      temp_q    <= TEMP_INVALID;
    end else begin
      temp_on_q <= temp_on_w;
      if (temp_on_w && !temp_on_q) begin
        temp_q <= TEMP_INVALID; // [R16]
      end else if (temp_ev_w) begin
        temp_q <= temp_clip_w; // [R15]
      end
    end
  end

  // Shadow capture on low-byte reads
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_hi_q  <= '0;
      gyr_hi_q  <= '0;
      temp_hi_q <= '0;
      st_snap_q <= '0;
    end else if (rd_en) begin
      for (int a = 0; a < 3; a++) begin
        if (addr == ACC_DATA_ADDR + 8'(2*a)) begin
          acc_hi_q[8*a +: 8] <= acc_smp_w[16*a + 8 +: 8]; // [R10] [R23]
        end
        if (addr == GYR_DATA_ADDR + 8'(2*a)) begin
          gyr_hi_q[8*a +: 8] <= gyr_smp_w[16*a + 8 +: 8]; // [R9] [R10]
        end
      end
      if (addr == TEMP_LO_ADDR) begin
        temp_hi_q <= temp_q[15:8];
      end
      if (addr == ST_B0_ADDR) begin
        st_snap_q <= st_w[23:8]; // [R22]
      end
    end
  end

  // Read selection
  wire [2:0] acc_idx_w = 3'(addr - ACC_DATA_ADDR);
  wire [2:0] gyr_idx_w = 3'(addr - GYR_DATA_ADDR);

  always_comb begin
    rd_mux_w = 8'h00;
    case (addr)
      STATUS_ADDR:     rd_mux_w = {6'h00, drdy_w};
      INT_STATUS_ADDR: rd_mux_w = {6'h00, int_stat_w};
      SENSOR_POWER_CONTROL_ADDR:   rd_mux_w = sensor_power_control_q;
      POWER_CONFIGURATION_ADDR:   rd_mux_w = power_configuration_q;
      ACC_CONF_ADDR:   rd_mux_w = acc_conf_q;
      GYR_CONF_ADDR:   rd_mux_w = gyr_conf_q;
      INT_MAP_ADDR:    rd_mux_w = int_map_q;
      TEMP_LO_ADDR:    rd_mux_w = temp_q[7:0];
      TEMP_HI_ADDR:    rd_mux_w = temp_hi_q;
      ST_B0_ADDR:      rd_mux_w = st_w[7:0]; // [R20]
      ST_B1_ADDR:      rd_mux_w = st_snap_q[7:0]; // [R22]
      ST_B2_ADDR:      rd_mux_w = st_snap_q[15:8]; // [R22]
      default: begin
        if (in_blk(addr, ACC_DATA_ADDR)) begin
          rd_mux_w = data_byte(acc_smp_w, acc_hi_q, acc_idx_w); // [R23]
        end else if (in_blk(addr, GYR_DATA_ADDR)) begin
          rd_mux_w = data_byte(gyr_smp_w, gyr_hi_q, gyr_idx_w); // [R9]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_en ? rd_mux_w : 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule // istr_top

//--- verif/istr_top_asserts.sv
// Purpose: Port-level checks of readout, data-ready pins and filter flag
// Assumes: Register writes seen at the ports mirror the config registers
// Notes:   Tick length in clocks comes from the bound parameter
`timescale 1ns/10ps
module istr_top_asserts
  import istr_pkg::*;
#(
  parameter longint ST_TICK_PS = istr_pkg::ST_TICK_PS
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       int1,
  input wire logic       int2,
  input wire logic       gyr_filt_normal
);
  localparam int T    = int'(ST_TICK_PS / CLK_PERIOD_PS);
  localparam int GAP  = 16 * T;
  // Tick phase is unknown, so the pulse may lose or gain a part of a tick
  localparam int HMIN = 3 * T - 1;
  localparam int HMAX = 4 * T + 2;
  logic [7:0]  map_q;
  logic [7:0]  acc_q;
  logic [7:0]  pwr_q;
  logic [15:0] gap_q;
  logic [15:0] hi_q;
  logic        armed_q;
  wire cfg_wr   = wr_en && (addr >= SENSOR_POWER_CONTROL_ADDR) && (addr <= INT_MAP_ADDR);
  wire acc_fast = (map_q == 8'h01) && acc_q[7] && (acc_q[3:0] == 4'hC);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      map_q <= INT_MAP_RST;
      acc_q <= ACC_CONF_RST;
      pwr_q <= SENSOR_POWER_CONTROL_RST;
    end else if (wr_en) begin
      map_q <= (addr == INT_MAP_ADDR) ? wdata : map_q;
      acc_q <= (addr == ACC_CONF_ADDR) ? wdata : acc_q;
      pwr_q <= (addr == SENSOR_POWER_CONTROL_ADDR) ? wdata : pwr_q;
    end
  end
  always_ff @(posedge clk) begin
    gap_q   <= $rose(int1) ? 16'h0001 : gap_q + 16'h0001;
    hi_q    <= int1 ? hi_q + 16'h0001 : 16'h0000;
    armed_q <= (!reset_n || cfg_wr) ? 1'b0 : (($rose(int1) && acc_fast) ? 1'b1 : armed_q);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_status_clr;
    rd_en && (addr == INT_STATUS_ADDR);
  endsequence
  a_rdata_quiet: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_status_bits: assert property (rd_en && addr == STATUS_ADDR |=> rdata[7:2] == 6'h00)
    else $error("status byte has stray bits");
  // Config lands at the write edge, the registered flag one edge later
  a_filt_on: assert property (wr_en && addr == GYR_CONF_ADDR
    && wdata[6:4] == GYR_BWP_NORMAL |=> ##1 gyr_filt_normal)
    else $error("normal filter flag not set");
  a_filt_off: assert property (wr_en && addr == GYR_CONF_ADDR
    && wdata[6:4] != GYR_BWP_NORMAL |=> ##1 !gyr_filt_normal)
    else $error("normal filter flag not clear");
  a_int_mapped: assert property (int1 |-> (map_q[0] || map_q[1]))
    else $error("pin one high while unmapped");
  a_acc_grid_gap: assert property ($rose(int1) && armed_q && acc_fast
    |-> gap_q == GAP) else $error("accel update spacing off grid");
  a_pulse_width: assert property ($fell(int1) && !map_q[4] && $stable(map_q)
    |-> hi_q >= HMIN && hi_q <= HMAX) else $error("ready pulse width wrong");
  a_pulse_bound: assert property (int1 && !map_q[4] |-> hi_q <= HMAX)
    else $error("ready pulse too long");
  a_latch_hold: assert property (int2 && map_q[4] && !(rd_en && addr == INT_STATUS_ADDR)
    && !(wr_en && addr == INT_MAP_ADDR) |=> int2) else $error("latched pin dropped");
  a_latch_clear: assert property (map_q == 8'h18 ##0 s_status_clr |=> !int2)
    else $error("latched pin not cleared by status read");
  a_gyr_enabled: assert property ($rose(int2) |-> pwr_q[PWR_GYR_EN_BIT])
    else $error("gyro ready while gyro disabled");
endmodule // istr_top_asserts

//--- verif/istr_host_model.sv
// Purpose: Host register master that reads results from the sensor block
// Assumes: One-cycle strobes; read data stands in the next cycle only
// Notes:   Expected bytes are queued as {addr, data, mask} for the monitor
`timescale 1ns/10ps
module istr_host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_en,
  output logic            rd_en
);
  logic [23:0] exp_q [$];
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Callers read a low byte before its high byte so the shadow pairs them
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back({a, e, m});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // X rate correction; the 7-bit factor must be sign-extended first
  function automatic logic signed [15:0] rate_x_fix(input logic signed [15:0] x,
    input logic signed [15:0] z, input logic [6:0] f);
    return x - 16'((32'($signed({{9{f[6]}}, f})) * 32'(z)) >>> 9);
  endfunction
endmodule // istr_host_model

//--- verif/istr_top_tb.sv
// Purpose: Self-checking bench for sample timing and readout
// Assumes: Sensortime step shortened to ten clocks
// Notes:   Monitor pops queued read expectations as read data appears
`timescale 1ns/10ps
module istr_top_tb;
  import istr_pkg::*;
  localparam longint TICK_PS = 64'd80000;
  localparam logic [15:0] RST_TAB [9] = '{16'h0400, 16'h0501, 16'h06A8, 16'h07A9,
    16'h0800, 16'h0000, 16'h1800, 16'h1980, 16'h4000};
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        int1;
  logic        int2;
  logic        gyr_filt_normal;
  logic        rd_p;
  logic [7:0]  rv;
  logic [15:0] temp_raw;
  logic [15:0] t;
  logic [23:0] ent;
  istr_axes_s  acc_raw;
  istr_axes_s  gyr_raw;
  istr_axes_s  v1;
  istr_axes_s  v2;
  int          checks;
  int          n_mismatch;
  istr_top #(.ST_TICK_PS(TICK_PS)) dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .acc_raw(acc_raw),
    .gyr_raw(gyr_raw), .temp_raw(temp_raw), .int1(int1), .int2(int2),
    .gyr_filt_normal(gyr_filt_normal));
  istr_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmp8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value rdata at %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Bounded wait so a dead pin ends as a mismatch, not a hang
  task automatic wait_pin(input int sel, input logic lvl, input int lim);
    int i;
    i = 0;
    while (((sel == 1) ? int1 : int2) !== lvl && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    cmp1("int pin", lvl, (sel == 1) ? int1 : int2);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_p <= rd_en;
    if (rd_p === 1'b1 && host.exp_q.size() > 0) begin
      ent = host.exp_q.pop_front();
      cmp8(ent[23:16], ent[15:8] & ent[7:0], rdata & ent[7:0]);
    end
  end
  initial begin
    #(20000 * 8);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    checks = 0;
    n_mismatch = 0;
    rd_p = 1'b0;
    reset_n = 1'b0;
    acc_raw = '0;
    gyr_raw = '0;
    temp_raw = 16'h0000;
    void'($urandom(32'h3AF5));
    v1 = istr_axes_s'(48'({$urandom, $urandom}));
    v2 = istr_axes_s'(48'({$urandom, $urandom}));
    t = 16'($urandom) & 16'h7FFF;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 9; k++) host.rd(RST_TAB[k][15:8], RST_TAB[k][7:0]);
    cmp1("gyr_filt_normal", 1'b1, gyr_filt_normal);
    for (int k = 5; k < 9; k++) begin
      rv = 8'($urandom);
      host.wr(8'(k), rv);
      host.rd(8'(k), rv);
      #1;
      if (k == 7) cmp1("gyr_filt_normal", rv[6:4] == 3'h2, gyr_filt_normal);
    end
    @(posedge clk);
    acc_raw <= v1;
    host.wr(POWER_CONFIGURATION_ADDR, 8'h00);
    host.wr(ACC_CONF_ADDR, 8'hAC);
    host.wr(INT_MAP_ADDR, 8'h01);
    host.wr(SENSOR_POWER_CONTROL_ADDR, 8'h01);
    wait_pin(1, 1'b1, 400);
    host.rd(STATUS_ADDR, 8'h01);
    host.rd(ACC_DATA_ADDR, v1.x[7:0]);
    host.rd(STATUS_ADDR, 8'h00);
    @(posedge clk);
    acc_raw <= v2;
    wait_pin(1, 1'b0, 100);
    wait_pin(1, 1'b1, 200);
    host.rd(ACC_DATA_ADDR + 8'h01, v1.x[15:8]);
    host.rd(ACC_DATA_ADDR + 8'h04, v2.z[7:0]);
    host.rd(ACC_DATA_ADDR + 8'h05, v2.z[15:8]);
    host.wr(SENSOR_POWER_CONTROL_ADDR, 8'h00);
    @(posedge clk);
    gyr_raw <= v1;
    temp_raw <= t;
    host.wr(POWER_CONFIGURATION_ADDR, 8'h01);
    host.wr(GYR_CONF_ADDR, 8'h08);
    host.wr(INT_MAP_ADDR, 8'h18);
    host.wr(SENSOR_POWER_CONTROL_ADDR, 8'h02);
    #1;
    cmp1("gyr_filt_normal", 1'b0, gyr_filt_normal);
    host.rd(TEMP_LO_ADDR, 8'h00);
    host.rd(TEMP_HI_ADDR, 8'h80);
    wait_pin(2, 1'b1, 3000);
    host.rd(STATUS_ADDR, 8'h02, 8'h02);
    host.rd(INT_STATUS_ADDR, 8'h02, 8'h02);
    wait_pin(2, 1'b0, 4);
    wait_pin(2, 1'b1, 3000);
    host.rd(GYR_DATA_ADDR, v1.x[7:0]);
    host.rd(GYR_DATA_ADDR + 8'h01, v1.x[15:8]);
    host.rd(STATUS_ADDR, 8'h00, 8'h02);
    host.rd(TEMP_LO_ADDR, t[7:0]);
    host.rd(TEMP_HI_ADDR, t[15:8]);
    host.wr(GYR_CONF_ADDR, 8'h28);
    repeat (4) @(posedge clk);
    cmp1("gyr_filt_normal", 1'b1, gyr_filt_normal);
    cmp1("x fix", 1'b1, host.rate_x_fix(16'sh0100, 16'sh0200, 7'h7F) == 16'sh0101);
    print_verdict;
  end
endmodule // istr_top_tb
bind istr_top istr_top_asserts #(.ST_TICK_PS(ST_TICK_PS)) u_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .int1(int1),
  .int2(int2), .gyr_filt_normal(gyr_filt_normal));
